// ===== ssp_params.svh
// Constants of the synchronous serial shift port
// Functional notes
// - see: 8-bit shift register, in/out/clock pins
// - see: master makes clock, slave receives it
// - see: interface select routes pins, enables block
// - see: rate bits: 2, 4, 8 cycle period
// - see: busy set starts, clears after eight
// - see: software busy clear stops shifting early
// - see: enabled interrupt after eight bits shifted
// - see: internal clock stops after eight pulses
// - see: pin config bits: drive/float, int/ext
// - see: slave busy clears after eight pulses
// - see: load shift register only when idle (a write while busy also loads it)
// - see: set busy in slave during idle
// - see: port data bit5 sets idle level
// - see: normal: sample rising, change falling
// - see: alternate: sample falling, change rising
// - see: phase select is port pin6 config
// - see: normal when phase select equals polarity
// - see: phase select cleared at reset
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SSP_OFS_CTRL      4'h0
`define SSP_OFS_PCFG      4'h1
`define SSP_OFS_PDATA     4'h2
`define SSP_OFS_PSW       4'h3
`define SSP_OFS_SHIFT     4'h4
`define SSP_OFS_ISTAT     4'h5
`define SSP_OFS_IMASK     4'h6
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSP_CTRL_SEL      0
`define SSP_CTRL_SL0      1
`define SSP_CTRL_SL1      2
`define SSP_PCFG_SO       4
`define SSP_PCFG_SK       5
`define SSP_PCFG_PHASE    6
`define SSP_PDATA_POL     5
`define SSP_PSW_BUSY      0
`define SSP_IST_DONE      0
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define SSP_RST_CTRL      3'h0
`define SSP_RST_PCFG      3'h0
`define SSP_RST_BYTE      8'h00
`define SSP_HALF_DIV2     3'h1
`define SSP_HALF_DIV4     3'h2
`define SSP_HALF_DIV8     3'h4
`define SSP_BITS          4'h8
`endif

// ===== ssp_pkg.sv
// Types of the synchronous serial shift port
package ssp_pkg;
   typedef enum logic [1:0] {
      SSP_RATE_2 = 2'b00,
      SSP_RATE_4 = 2'b01,
      SSP_RATE_8 = 2'b10,
      SSP_RATE_8B = 2'b11
   } ssp_rate_t;
   typedef enum logic {
      SSP_ST_IDLE  = 1'b0,
      SSP_ST_SHIFT = 1'b1
   } ssp_state_t;
endpackage

// ===== ssp_edge_if.sv
// Shift clock level and edge strobes between modules
`timescale 1ns/100ps
`default_nettype none
interface ssp_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, rise, fall);
   modport dst (input level, rise, fall);
endinterface
`default_nettype wire

// ===== ssp_pin_sync.sv
// Pin synchroniser and shift clock edge finder
`timescale 1ns/100ps
`default_nettype none
module ssp_pin_sync (
   input  wire logic ref_clk_i,
   input  wire logic reset_i,
   input  wire logic sk_pin_i,
   input  wire logic si_pin_i,
   output var  logic si_o,
   ssp_edge_if.src   edge_o
);
   import ssp_pkg::*;
   logic [1:0] sk_meta_reg;
   logic       sk_last_reg;
   logic       si_meta_reg;
   // Two flops per pin, a third stage for edges
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         sk_meta_reg <= 2'h0;
         sk_last_reg <= 1'h0;
         si_meta_reg <= 1'h0;
         si_o        <= 1'h0;
         edge_o.level <= 1'h0;
         edge_o.rise  <= 1'h0;
         edge_o.fall  <= 1'h0;
      end else begin
         sk_meta_reg <= {sk_meta_reg[0], sk_pin_i};
         sk_last_reg <= sk_meta_reg[1];
         si_meta_reg <= si_pin_i;
         si_o        <= si_meta_reg;
         edge_o.level <= sk_meta_reg[1];
         edge_o.rise  <= sk_meta_reg[1] & ~sk_last_reg;
         edge_o.fall  <= ~sk_meta_reg[1] & sk_last_reg;
      end
   end
endmodule
`default_nettype wire

// ===== ssp_clk_gen.sv
// Master shift clock divider
`timescale 1ns/100ps
`default_nettype none
`include "ssp_params.svh"
module ssp_clk_gen (
   input  wire logic              ref_clk_i,
   input  wire logic              reset_i,
   input  wire logic              run_i,
   input  wire logic              idle_pol_i,
   input  wire ssp_pkg::ssp_rate_t rate_i,
   ssp_edge_if.src                edge_o
);
   import ssp_pkg::*;
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic       lvl_next;
   logic       rise_next;
   logic       fall_next;
   // Half period in reference cycles
   function automatic logic [2:0] half_of(input ssp_rate_t r);
      case (r)
         SSP_RATE_2: half_of = `SSP_HALF_DIV2;
         SSP_RATE_4: half_of = `SSP_HALF_DIV4;
         default:    half_of = `SSP_HALF_DIV8;
      endcase
   endfunction
   // Toggle every half period while running
   always_comb begin
      cnt_next  = cnt_reg;
      lvl_next  = edge_o.level;
      rise_next = 1'b0;
      fall_next = 1'b0;
      if (!run_i) begin
         cnt_next = 3'h0;
         lvl_next = idle_pol_i;
      end else if (cnt_reg == half_of(rate_i) - 3'h1) begin
         cnt_next  = 3'h0;
         lvl_next  = ~edge_o.level;
         rise_next = ~edge_o.level;
         fall_next = edge_o.level;
      end else begin
         cnt_next = cnt_reg + 3'h1;
      end
   end
   // Register the divider state
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         cnt_reg      <= 3'h0;
         edge_o.level <= 1'h0;
         edge_o.rise  <= 1'h0;
         edge_o.fall  <= 1'h0;
      end else begin
         cnt_reg      <= cnt_next;
         edge_o.level <= lvl_next;
         edge_o.rise  <= rise_next;
         edge_o.fall  <= fall_next;
      end
   end
endmodule
`default_nettype wire

// ===== ssp_top.sv
// Synchronous serial shift port with Avalon-MM register access
`timescale 1ns/100ps
`default_nettype none
`include "ssp_params.svh"
module ssp_top (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output var  logic [31:0] avs_readdata_o,
   output var  logic        avs_waitrequest_o,
   input  wire logic        si_pin_i,
   input  wire logic        sk_pin_i,
   output var  logic        so_pin_o,
   output var  logic        so_pin_oe_o,
   output var  logic        sk_pin_o,
   output var  logic        sk_pin_oe_o,
   output var  logic        irq_o
);
   import ssp_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ssp_state_t  state_reg,  state_next;
   logic [2:0]  ctrl_reg,   ctrl_next;
   logic [2:0]  pcfg_reg,   pcfg_next;
   logic        pol_reg,    pol_next;
   logic [7:0]  shift_reg,  shift_next;
   logic [7:0]  tx_reg,     tx_next;
   logic [3:0]  cnt_reg,    cnt_next;
   logic        ist_reg,    ist_next;
   logic        imask_reg,  imask_next;
   logic        ack_reg,    ack_next;
   logic [31:0] rdata_reg,  rdata_next;
   logic        so_reg,     so_next;
   logic [1:0]  sdly_reg,   sdly_next;
   logic        sk_next;
   logic        irq_next;
   logic        si_sync;
   logic        sel;
   logic        master;
   logic        normal;
   logic        busy;
   logic        s_edge;
   logic        o_edge;
   logic        t_edge;
   logic        done;
   logic        wr;
   logic        rd;
   logic        ev_rise;
   logic        ev_fall;
   ssp_edge_if  ext_edge ();
   ssp_edge_if  int_edge ();

   // ----------------------------------------------------------------
   // Clock sources
   // ----------------------------------------------------------------
   ssp_pin_sync u_sync (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .sk_pin_i  (sk_pin_i),
      .si_pin_i  (si_pin_i),
      .si_o      (si_sync),
      .edge_o    (ext_edge.src)
   );

   ssp_clk_gen u_gen (
      .ref_clk_i  (ref_clk_i),
      .reset_i    (reset_i),
      .run_i      (busy & master & sel),
      .idle_pol_i (pol_reg),
      .rate_i     (ssp_rate_t'({ctrl_reg[`SSP_CTRL_SL1], ctrl_reg[`SSP_CTRL_SL0]})),
      .edge_o     (int_edge.src)
   );

   // ----------------------------------------------------------------
   // Decode of mode and edges
   // ----------------------------------------------------------------
   // Select source, phase and the three edge roles
   always_comb begin
      sel     = ctrl_reg[`SSP_CTRL_SEL];
      master  = pcfg_reg[`SSP_PCFG_SK - 4];
      normal  = (pcfg_reg[`SSP_PCFG_PHASE - 4] == pol_reg);
      busy    = (state_reg == SSP_ST_SHIFT);
      ev_rise = master ? int_edge.rise : ext_edge.rise;
      ev_fall = master ? int_edge.fall : ext_edge.fall;
      s_edge  = busy & sel & (normal ? ev_rise : ev_fall);
      o_edge  = busy & sel & (normal ? ev_fall : ev_rise);
      t_edge  = busy & sel & (pol_reg ? ev_rise : ev_fall);
      done    = t_edge & (cnt_reg == `SSP_BITS - 4'h1);
      wr      = ack_reg & avs_write_i;
      rd      = avs_read_i | avs_write_i;
   end

   // ----------------------------------------------------------------
   // Registers, shifter and bus answer
   // ----------------------------------------------------------------
   // Next values of all control and data state
   always_comb begin
      state_next = state_reg;
      ctrl_next  = ctrl_reg;
      pcfg_next  = pcfg_reg;
      pol_next   = pol_reg;
      shift_next = shift_reg;
      tx_next    = tx_reg;
      cnt_next   = cnt_reg;
      ist_next   = ist_reg;
      imask_next = imask_reg;
      ack_next   = 1'b0;
      rdata_next = rdata_reg;
      so_next    = so_reg;
      // Request seen: answer one cycle later
      if (rd && !ack_reg) begin
         ack_next   = 1'b1;
         rdata_next = 32'h0000_0000;
         case (avs_address_i)
            `SSP_OFS_CTRL:  rdata_next = {29'h0, ctrl_reg};
            `SSP_OFS_PCFG:  rdata_next = {25'h0, pcfg_reg, 4'h0};
            `SSP_OFS_PDATA: rdata_next = {26'h0, pol_reg, 5'h0};
            `SSP_OFS_PSW:   rdata_next = {31'h0, busy};
            `SSP_OFS_SHIFT: rdata_next = {24'h0, shift_reg};
            `SSP_OFS_ISTAT: rdata_next = {31'h0, ist_reg};
            `SSP_OFS_IMASK: rdata_next = {31'h0, imask_reg};
            default:        rdata_next = 32'h0000_0000;
         endcase
      end
      // Shift engine, MSB out first, LSB in
      // Master capture waits out pin and synchroniser delay
      sdly_next = {sdly_reg[0], s_edge & master};
      if (master ? sdly_reg[1] : s_edge) begin
         shift_next = {shift_reg[6:0], si_sync};
      end
      if (o_edge) begin
         so_next = tx_reg[7];
         tx_next = {tx_reg[6:0], 1'b0};
      end
      if (t_edge) begin
         cnt_next = cnt_reg + 4'h1;
      end
      if (done) begin
         state_next = SSP_ST_IDLE;
      end
      // Software writes on the answering edge
      if (wr) begin
         case (avs_address_i)
            `SSP_OFS_CTRL:  ctrl_next = avs_writedata_i[2:0];
            `SSP_OFS_PCFG:  pcfg_next = avs_writedata_i[6:4];
            `SSP_OFS_PDATA: pol_next  = avs_writedata_i[`SSP_PDATA_POL];
            `SSP_OFS_PSW: begin
               if (avs_writedata_i[`SSP_PSW_BUSY] && !busy) begin
                  state_next = SSP_ST_SHIFT;
                  cnt_next   = 4'h0;
               end else if (!avs_writedata_i[`SSP_PSW_BUSY]) begin
                  state_next = SSP_ST_IDLE;
               end
            end
            `SSP_OFS_SHIFT: shift_next = avs_writedata_i[7:0];
            `SSP_OFS_ISTAT: begin
               if (avs_writedata_i[`SSP_IST_DONE]) begin
                  ist_next = 1'b0;
               end
            end
            `SSP_OFS_IMASK: imask_next = avs_writedata_i[0];
            default: ;
         endcase
      end
      // Completion event wins over a clear
      if (done) begin
         ist_next = 1'b1;
      end
      // While idle the output shows the MSB, skipped if first edge samples
      if (!busy) begin
         so_next = shift_next[7];
         tx_next = (normal != pol_reg) ? {shift_next[6:0], 1'b0} : shift_next;
      end
   end

   // Pin drivers and interrupt line
   always_comb begin
      sk_next  = (busy && master) ? int_edge.level : pol_reg;
      irq_next = ist_reg & imask_reg;
   end

   // Register every state group and output
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_reg         <= SSP_ST_IDLE;
         ctrl_reg          <= `SSP_RST_CTRL;
         pcfg_reg          <= `SSP_RST_PCFG;
         pol_reg           <= 1'b0;
         shift_reg         <= `SSP_RST_BYTE;
         tx_reg            <= `SSP_RST_BYTE;
         cnt_reg           <= 4'h0;
         sdly_reg          <= 2'h0;
         ist_reg           <= 1'b0;
         imask_reg         <= 1'b0;
         ack_reg           <= 1'b0;
         rdata_reg         <= 32'h0000_0000;
         so_reg            <= 1'b0;
         avs_readdata_o    <= 32'h0000_0000;
         avs_waitrequest_o <= 1'b1;
         so_pin_o          <= 1'b0;
         so_pin_oe_o       <= 1'b0;
         sk_pin_o          <= 1'b0;
         sk_pin_oe_o       <= 1'b0;
         irq_o             <= 1'b0;
      end else begin
         state_reg         <= state_next;
         ctrl_reg          <= ctrl_next;
         pcfg_reg          <= pcfg_next;
         pol_reg           <= pol_next;
         shift_reg         <= shift_next;
         tx_reg            <= tx_next;
         cnt_reg           <= cnt_next;
         sdly_reg          <= sdly_next;
         ist_reg           <= ist_next;
         imask_reg         <= imask_next;
         ack_reg           <= ack_next;
         rdata_reg         <= rdata_next;
         so_reg            <= so_next;
         avs_readdata_o    <= rdata_next;
         avs_waitrequest_o <= ~ack_next;
         so_pin_o          <= so_next;
         so_pin_oe_o       <= ctrl_next[`SSP_CTRL_SEL] & pcfg_next[0];
         sk_pin_o          <= sk_next;
         sk_pin_oe_o       <= ctrl_next[`SSP_CTRL_SEL] & pcfg_next[1];
         irq_o             <= irq_next;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   property p_done_clears_busy;
      done && !wr |=> state_reg == SSP_ST_IDLE;
   endproperty
   a_done_clears_busy: assert property (p_done_clears_busy)
      else $error("busy did not clear after eighth bit");

   property p_sw_clear_stops;
      wr && avs_address_i == `SSP_OFS_PSW && !avs_writedata_i[0] |=> !busy ##1 !s_edge;
   endproperty
   a_sw_clear_stops: assert property (p_sw_clear_stops)
      else $error("shifting continued after software clear");

   property p_done_flag;
      done |=> ist_reg ##1 (irq_o == imask_reg);
   endproperty
   a_done_flag: assert property (p_done_flag)
      else $error("completion flag or interrupt wrong");

   property p_rate2;
      int_edge.rise && ctrl_reg[2:1] == 2'b00 && busy |=> int_edge.fall || !busy;
   endproperty
   a_rate2: assert property (p_rate2)
      else $error("two cycle shift clock period wrong");

   property p_rate8;
      int_edge.rise && ctrl_reg[2] && $stable(ctrl_reg) |=> (!int_edge.fall)[*3];
   endproperty
   a_rate8: assert property (p_rate8)
      else $error("eight cycle shift clock period wrong");

   property p_count_bound;
      cnt_reg <= `SSP_BITS;
   endproperty
   a_count_bound: assert property (p_count_bound)
      else $error("more than eight pulses counted");

   property p_pins_off;
      !ctrl_next[0] |=> !so_pin_oe_o && !sk_pin_oe_o;
   endproperty
   a_pins_off: assert property (p_pins_off)
      else $error("pin driven with interface deselected");

   property p_idle_level;
      !busy && !$past(busy) |=> sk_pin_o == $past(pol_reg);
   endproperty
   a_idle_level: assert property (p_idle_level)
      else $error("shift clock not at idle level");

   property p_reset_phase;
      $fell(reset_i) |-> pcfg_reg[2] == 1'b0;
   endproperty
   a_reset_phase: assert property (@(posedge ref_clk_i) p_reset_phase)
      else $error("phase select not cleared by reset");
endmodule
`default_nettype wire

// ===== ssp_far_model.sv
// Behavioural far-side party of the serial link
`timescale 1ns/100ps
`default_nettype none
module ssp_far_model (
   input  wire logic       sk_i,
   input  wire logic       so_i,
   input  wire logic       alt_i,
   input  wire logic       pol_i,
   output var  logic       si_o,
   output var  logic       sk_o,
   output var  logic [7:0] rx_o,
   output var  int         edges_o
);
   logic [7:0] tx;
   logic       sampled;
   initial begin
      si_o = 1'b0;
      sk_o = 1'b0;
      rx_o = 8'h00;
      edges_o = 0;
      tx = 8'h00;
      sampled = 1'b0;
   end
   // ----------------------------------------------------------------
   // Frame setup and external clock
   // ----------------------------------------------------------------
   task automatic load(input logic [7:0] d);
      tx = d;
      si_o = d[7];
      rx_o = 8'h00;
      edges_o = 0;
      sampled = 1'b0;
      sk_o = pol_i;
   endtask
   // Clock only inside frames, idle level between them
   task automatic run_clock(input int n);
      #13;
      repeat (n) begin
         sk_o = ~pol_i;
         #40;
         sk_o = pol_i;
         #40;
      end
   endtask
   // Sample on one edge, change on the other
   always @(sk_i) begin
      if (sk_i === 1'b1 || sk_i === 1'b0) begin
         edges_o = edges_o + 1;
         if ((sk_i === 1'b1) != alt_i) begin
            rx_o = {rx_o[6:0], so_i};
            sampled = 1'b1;
         end else if (sampled) begin
            tx = {tx[6:0], ~tx[7]};
            si_o = tx[7];
         end
      end
   end
endmodule
`default_nettype wire

// ===== ssp_top_test.sv
// Self-checking bench of the serial shift port
`timescale 1ns/100ps
`default_nettype none
`include "ssp_params.svh"
module ssp_top_test;
   logic        ref_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [3:0]  avs_address_i = 4'h0;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        so_pin_o;
   logic        so_pin_oe_o;
   logic        sk_pin_o;
   logic        sk_pin_oe_o;
   logic        irq_o;
   logic        far_si;
   logic        far_sk;
   logic [7:0]  far_rx;
   int          far_edges;
   logic        far_alt = 1'b0;
   logic        far_pol = 1'b0;
   int          error_cnt = 0;
   int          n_tests = 0;
   logic        sk_q = 1'b0;
   int          cyc = 0;
   int          last_rise = 0;
   int          per = 0;
   // Wire levels: whoever enables drives, a floating data line flips
   wire logic   sk_w = sk_pin_oe_o ? sk_pin_o : far_sk;
   wire logic   so_w = so_pin_oe_o ? so_pin_o : ~so_pin_o;
   always #2 ref_clk_i = ~ref_clk_i;
   // ----------------------------------------------------------------
   // Design and far side
   // ----------------------------------------------------------------
   ssp_top u_dut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .si_pin_i(far_si), .sk_pin_i(sk_w),
      .so_pin_o(so_pin_o), .so_pin_oe_o(so_pin_oe_o), .sk_pin_o(sk_pin_o),
      .sk_pin_oe_o(sk_pin_oe_o), .irq_o(irq_o)
   );
   ssp_far_model u_far (
      .sk_i(sk_w), .so_i(so_w), .alt_i(far_alt), .pol_i(far_pol),
      .si_o(far_si), .sk_o(far_sk), .rx_o(far_rx), .edges_o(far_edges)
   );
   // Shift clock period between rising edges
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      sk_q <= sk_pin_o;
      if (sk_pin_o === 1'b1 && sk_q === 1'b0) begin
         per <= cyc - last_rise;
         last_rise <= cyc;
      end
   end
   // ----------------------------------------------------------------
   // Bus access and compare tasks
   // ----------------------------------------------------------------
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int k;
      k = 0;
      @(posedge ref_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= ~w;
      @(posedge ref_clk_i);
      while (avs_waitrequest_o !== 1'b0 && k < 50) begin
         k++;
         @(posedge ref_clk_i);
      end
      if (k >= 50) begin
         error_cnt++;
         $display("[FAIL] bus_wait expected 0 seen %b", avs_waitrequest_o);
      end
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      // Let the answering edge settle before pins are looked at
      @(negedge ref_clk_i);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      acc(1'b0, a, 32'h0, q);
      chk(nm, exp, q);
   endtask
   // Poll busy until it drops
   task automatic wait_idle();
      logic [31:0] q;
      repeat (200) begin
         acc(1'b0, `SSP_OFS_PSW, 32'h0, q);
         if (q[0] === 1'b0) break;
      end
      if (q[0] !== 1'b0) begin
         error_cnt++;
         $display("[FAIL] busy expected 0 seen %b", q[0]);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      tally_and_finish();
   end
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] mt;
      logic [7:0] st;
      int         e;
      repeat (10) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      // Reset values, unmapped index, pin routing
      chk("pins_rst", 32'h0, {so_pin_oe_o, sk_pin_oe_o, irq_o});
      for (int a = 0; a < 8; a++) rdchk("reg_rst", a[3:0], 32'h0);
      wr(`SSP_OFS_PCFG, 32'h70);
      rdchk("pcfg", `SSP_OFS_PCFG, 32'h70);
      chk("oe_unsel", 32'h0, {so_pin_oe_o, sk_pin_oe_o});
      wr(`SSP_OFS_PCFG, 32'h20);
      wr(`SSP_OFS_CTRL, 32'h1);
      chk("oe_sel", 32'h1, {so_pin_oe_o, sk_pin_oe_o});
      // Master transfers over rates, polarities and phases
      for (int i = 0; i < 4; i++) begin
         mt = 8'h1E + 8'h11 * i[7:0];
         st = 8'hB2 ^ i[7:0];
         far_pol = i[0];
         far_alt = i[0] ^ i[1];
         wr(`SSP_OFS_PDATA, 32'(i[0]) << 5);
         wr(`SSP_OFS_PCFG, 32'h30 | (32'(i[1]) << 6));
         wr(`SSP_OFS_CTRL, 32'h1 | (32'(i) << 1));
         wr(`SSP_OFS_IMASK, 32'(i[0]));
         wr(`SSP_OFS_SHIFT, 32'(mt));
         u_far.load(st);
         chk("sk_idle", 32'(i[0]), sk_pin_o);
         chk("oe_m", 32'h3, {so_pin_oe_o, sk_pin_oe_o});
         wr(`SSP_OFS_PSW, 32'h1);
         wait_idle();
         chk("period", (i == 0) ? 2 : (i == 1) ? 4 : 8, per);
         chk("far_rx", 32'(mt), far_rx);
         rdchk("shift_m", `SSP_OFS_SHIFT, 32'(st));
         chk("edges_m", 32'd16, far_edges);
         rdchk("done", `SSP_OFS_ISTAT, 32'h1);
         chk("irq", 32'(i[0]), irq_o);
         wr(`SSP_OFS_ISTAT, 32'h1);
         rdchk("done_clr", `SSP_OFS_ISTAT, 32'h0);
         chk("irq_clr", 32'h0, irq_o);
      end
      // Software stop in mid-transfer
      far_pol = 1'b0;
      far_alt = 1'b0;
      wr(`SSP_OFS_PDATA, 32'h0);
      wr(`SSP_OFS_PCFG, 32'h30);
      wr(`SSP_OFS_CTRL, 32'h5);
      wr(`SSP_OFS_IMASK, 32'h1);
      u_far.load(8'h5C);
      wr(`SSP_OFS_PSW, 32'h1);
      repeat (200) if (far_edges < 6) @(posedge ref_clk_i);
      wr(`SSP_OFS_PSW, 32'h0);
      rdchk("busy_stop", `SSP_OFS_PSW, 32'h0);
      e = far_edges;
      repeat (40) @(posedge ref_clk_i);
      chk("edges_stop", 32'(e), far_edges);
      rdchk("no_done", `SSP_OFS_ISTAT, 32'h0);
      chk("irq_stop", 32'h0, irq_o);
      // Slave transfer on the far side's clock
      wr(`SSP_OFS_PCFG, 32'h10);
      wr(`SSP_OFS_CTRL, 32'h1);
      wr(`SSP_OFS_SHIFT, 32'h6A);
      u_far.load(8'h93);
      chk("oe_s", 32'h2, {so_pin_oe_o, sk_pin_oe_o});
      wr(`SSP_OFS_PSW, 32'h1);
      u_far.run_clock(8);
      wait_idle();
      chk("far_rx_s", 32'h6A, far_rx);
      rdchk("shift_s", `SSP_OFS_SHIFT, 32'h93);
      rdchk("done_s", `SSP_OFS_ISTAT, 32'h1);
      chk("irq_s", 32'h1, irq_o);
      // Pulses after the frame leave the register alone
      u_far.load(8'h0F);
      u_far.run_clock(8);
      rdchk("shift_hold", `SSP_OFS_SHIFT, 32'h93);
      tally_and_finish();
   end
endmodule
`default_nettype wire
